// file: stf_pin_model.sv
module stf_pin_model (
  // Clock
  input  wire logic clk_i,
  // Pins toward the block
  output logic      ext_irq_a_input_o,
  output logic      ext_irq_b_input_o,
  output logic      first_timer_event_o,
  output logic      second_timer_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle high, as pulled up
  initial begin
    ext_irq_a_input_o = 1'b1;
    ext_irq_b_input_o = 1'b1;
    first_timer_event_o = 1'b1;
    second_timer_event_o = 1'b1;
  end
  task automatic set_ext(input int idx, input logic lvl);
    @(posedge clk_i);
    if (idx == 0) ext_irq_a_input_o <= lvl;
    else ext_irq_b_input_o <= lvl;
  endtask : set_ext
  // Each level is held at least two clocks so the sampler cannot miss it
  task automatic event_falls(input int n);
    repeat (n) begin
      @(posedge clk_i);
      first_timer_event_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      first_timer_event_o <= 1'b1;
      repeat (2) @(posedge clk_i);
    end
  endtask : event_falls
endmodule : stf_pin_model

// file: stf_pin_sync.sv
module stf_pin_sync (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Raw pins
  input  wire logic [stf_pkg::STF_PIN_W-1:0] pin_i,
  // Filtered levels and falling-edge pulses
  output logic      [stf_pkg::STF_PIN_W-1:0] level_o,
  output logic      [stf_pkg::STF_PIN_W-1:0] fall_o
);

  logic [stf_pkg::STF_PIN_W-1:0] s1_reg;
  logic [stf_pkg::STF_PIN_W-1:0] s2_reg;
  logic [stf_pkg::STF_PIN_W-1:0] s3_reg;
  logic [stf_pkg::STF_PIN_W-1:0] level_reg;
  logic [stf_pkg::STF_PIN_W-1:0] level_next;
  logic [stf_pkg::STF_PIN_W-1:0] fall_reg;
  logic [stf_pkg::STF_PIN_W-1:0] fall_next;

  // A change is taken only once stages two and three agree, so one noisy sample is ignored
  always_comb begin
    level_next = level_reg;
    fall_next  = '0;
    for (int i = 0; i < stf_pkg::STF_PIN_W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
        fall_next[i]  = level_reg[i] & ~s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg    <= stf_pkg::STF_RST_PINS;
      s2_reg    <= stf_pkg::STF_RST_PINS;
      s3_reg    <= stf_pkg::STF_RST_PINS;
      level_reg <= stf_pkg::STF_RST_PINS;
      fall_reg  <= '0;
    end else begin
      s1_reg    <= pin_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
      fall_reg  <= fall_next;
    end
  end

  assign level_o = level_reg;
  assign fall_o  = fall_reg;

endmodule : stf_pin_sync

// file: stf_pkg.sv
package stf_pkg;

  // Special-function register addresses
  localparam logic [7:0] STF_ADDR_RUN_FLAGS = 8'h88;
  localparam logic [7:0] STF_ADDR_MODE      = 8'h89;
  localparam logic [7:0] STF_ADDR_T0_LOW    = 8'h8a;
  localparam logic [7:0] STF_ADDR_T1_LOW    = 8'h8b;
  localparam logic [7:0] STF_ADDR_T0_HIGH   = 8'h8c;
  localparam logic [7:0] STF_ADDR_T1_HIGH   = 8'h8d;

  // Field positions inside timer_run_and_irq_flags
  localparam int STF_POS_T1_OVF  = 7;
  localparam int STF_POS_T1_RUN  = 6;
  localparam int STF_POS_T0_OVF  = 5;
  localparam int STF_POS_T0_RUN  = 4;
  localparam int STF_POS_XB_FLAG = 3;
  localparam int STF_POS_XB_TRIG = 2;
  localparam int STF_POS_XA_FLAG = 1;
  localparam int STF_POS_XA_TRIG = 0;

  // Reset values
  localparam logic [7:0] STF_RST_RUN_FLAGS = 8'h00;
  localparam logic [7:0] STF_RST_MODE      = 8'h00;
  localparam logic [7:0] STF_RST_COUNT     = 8'h00;
  localparam logic [7:0] STF_RDATA_UNMAPPED = 8'h00;

  // Pin synchroniser lanes
  localparam int STF_PIN_W       = 4;
  localparam int STF_PIN_EXT_A   = 0;
  localparam int STF_PIN_EXT_B   = 1;
  localparam int STF_PIN_EVENT_0 = 2;
  localparam int STF_PIN_EVENT_1 = 3;
  localparam logic [STF_PIN_W-1:0] STF_RST_PINS = 4'hf;

  // Interrupt acknowledge lanes
  localparam int STF_ACK_XA = 0;
  localparam int STF_ACK_T0 = 1;
  localparam int STF_ACK_XB = 2;
  localparam int STF_ACK_T1 = 3;

  // Counting limits
  localparam logic [4:0] STF_LOW5_MAX = 5'h1f;
  localparam logic [7:0] STF_BYTE_MAX = 8'hff;

  typedef enum logic [1:0] {
    STF_MODE_13BIT,
    STF_MODE_16BIT,
    STF_MODE_RELOAD8,
    STF_MODE_SPLIT
  } stf_mode_t;

  typedef struct packed {
    logic       t1_gate;
    logic       count_sel1;
    logic [1:0] mode1;
    logic       t0_gate;
    logic       count_sel0;
    logic [1:0] mode0;
  } stf_mod_t;

  typedef struct packed {
    logic t1_ovf;
    logic t1_run;
    logic t0_ovf;
    logic t0_run;
    logic xb_flag;
    logic xb_trig;
    logic xa_flag;
    logic xa_trig;
  } stf_flg_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } stf_cnt_t;

endpackage : stf_pkg

// file: stf_timer_core.sv
// Behaviour
// RULE1 - Split mode makes two separate 8-bit counters
// RULE2 - Low byte uses first timer's controls
// RULE3 - Low byte counts clock or event falls
// RULE4 - High byte is timer only, no events
// RULE5 - High byte runs only with second run
// RULE6 - High byte overflow sets second overflow flag
// RULE7 - Second timer counts internally, no flag
// RULE8 - Second timer overflow pulses stay available
// RULE9 - Second timer mode 3 stops it
// RULE10 - External flags set by chosen trigger type
// RULE11 - Edge flags clear by software or vector
// RULE12 - Level flag follows active input
// RULE13 - Trigger select: zero level, one edge
// RULE14 - Polarity bits set active input level
// RULE15 - Gate enable needs active external input
// RULE16 - Sysclk select picks clock or prescaled tick
// RULE17 - Overflow flags set, cleared by software or vector
// RULE18 - Run bits enable without clearing count
module stf_timer_core (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Special-function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Clock-scale and pin configuration bits
  input  wire logic       prescale_tick_i,
  input  wire logic       first_timer_sysclk_select_i,
  input  wire logic       second_timer_sysclk_select_i,
  input  wire logic       ext_irq_a_polarity_i,
  input  wire logic       ext_irq_b_polarity_i,
  // Pins
  input  wire logic       ext_irq_a_input_i,
  input  wire logic       ext_irq_b_input_i,
  input  wire logic       first_timer_event_i,
  input  wire logic       second_timer_event_i,
  // Interrupt controller
  input  wire logic [3:0] irq_vector_ack_i,
  output logic            ext_irq_a_flag_o,
  output logic            first_timer_overflow_flag_o,
  output logic            ext_irq_b_flag_o,
  output logic            second_timer_overflow_flag_o,
  // Baud and conversion trigger
  output logic            second_timer_overflow_pulse_o
);

  stf_pkg::stf_flg_t  flg_reg;
  stf_pkg::stf_flg_t  flg_next;
  stf_pkg::stf_mod_t  mod_reg;
  stf_pkg::stf_mod_t  mod_next;
  logic [7:0]         t0_low_reg;
  logic [7:0]         t0_low_next;
  logic [7:0]         t0_high_reg;
  logic [7:0]         t0_high_next;
  logic [7:0]         t1_low_reg;
  logic [7:0]         t1_low_next;
  logic [7:0]         t1_high_reg;
  logic [7:0]         t1_high_next;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  logic               t1_pulse_reg;
  logic               t1_pulse_next;
  logic               act_a_reg;
  logic               act_a_next;
  logic               act_b_reg;
  logic               act_b_next;

  logic [stf_pkg::STF_PIN_W-1:0] pin_raw;
  logic [stf_pkg::STF_PIN_W-1:0] pin_level;
  logic [stf_pkg::STF_PIN_W-1:0] pin_fall;

  stf_pkg::stf_mode_t mode0;
  stf_pkg::stf_mode_t mode1;
  logic               split;
  logic               act_a;
  logic               act_b;
  logic               base0;
  logic               base1;
  logic               tick0;
  logic               tick_high;
  logic               tick1;
  logic               wr_flg;
  logic               edge_a;
  logic               edge_b;
  logic               set_tf0;
  logic               set_tf1;
  stf_pkg::stf_cnt_t  step0;
  stf_pkg::stf_cnt_t  step1;

  // One counting step for any of the three shared modes; split is handled outside
  function automatic stf_pkg::stf_cnt_t count_step(input stf_pkg::stf_mode_t mode,
                                                   input logic [7:0]         low,
                                                   input logic [7:0]         high,
                                                   input logic               tick);
    stf_pkg::stf_cnt_t r;
    logic [15:0]       wide;
    r.low  = low;
    r.high = high;
    r.ovf  = 1'b0;
    wide   = {high, low} + 16'h0001;
    if (tick) begin
      case (mode)
        stf_pkg::STF_MODE_13BIT: begin
          // Upper three low-byte bits are left untouched and read as junk
          r.low[4:0] = low[4:0] + 5'h01;
          if (low[4:0] == stf_pkg::STF_LOW5_MAX) begin
            r.high = high + 8'h01;
            r.ovf  = (high == stf_pkg::STF_BYTE_MAX);
          end
        end
        stf_pkg::STF_MODE_16BIT: begin
          r.low  = wide[7:0];
          r.high = wide[15:8];
          r.ovf  = ({high, low} == {stf_pkg::STF_BYTE_MAX, stf_pkg::STF_BYTE_MAX});
        end
        stf_pkg::STF_MODE_RELOAD8: begin
          r.low = (low == stf_pkg::STF_BYTE_MAX) ? high : low + 8'h01;
          r.ovf = (low == stf_pkg::STF_BYTE_MAX);
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction : count_step

  assign pin_raw[stf_pkg::STF_PIN_EXT_A]   = ext_irq_a_input_i;
  assign pin_raw[stf_pkg::STF_PIN_EXT_B]   = ext_irq_b_input_i;
  assign pin_raw[stf_pkg::STF_PIN_EVENT_0] = first_timer_event_i;
  assign pin_raw[stf_pkg::STF_PIN_EVENT_1] = second_timer_event_i;

  stf_pin_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (pin_raw),
    .level_o (pin_level),
    .fall_o  (pin_fall)
  );

  // Timebase and enable terms
  always_comb begin
    mode0 = stf_pkg::stf_mode_t'(mod_reg.mode0);
    mode1 = stf_pkg::stf_mode_t'(mod_reg.mode1);
    split = (mode0 == stf_pkg::STF_MODE_SPLIT);                               // see RULE1
    // Polarity one means active high
    act_a = ext_irq_a_polarity_i ? pin_level[stf_pkg::STF_PIN_EXT_A]
                                 : ~pin_level[stf_pkg::STF_PIN_EXT_A];      // see RULE14
    act_b = ext_irq_b_polarity_i ? pin_level[stf_pkg::STF_PIN_EXT_B]
                                 : ~pin_level[stf_pkg::STF_PIN_EXT_B];      // see RULE14
    base0 = first_timer_sysclk_select_i | prescale_tick_i;                  // see RULE16
    base1 = second_timer_sysclk_select_i | prescale_tick_i;                 // see RULE16
    // Low byte in split mode shares these first-timer controls
    tick0 = flg_reg.t0_run & (~mod_reg.t0_gate | act_a)
          & (mod_reg.count_sel0 ? pin_fall[stf_pkg::STF_PIN_EVENT_0]
                                 : base0);                                  // see RULE2, RULE3, RULE15, RULE18
    tick_high = split & flg_reg.t1_run & base0;                             // see RULE4, RULE5
    if (split) begin
      // Second timer runs on its mode alone and never on its pin
      tick1 = (mode1 != stf_pkg::STF_MODE_SPLIT) & base1;                   // see RULE7, RULE9
    end else begin
      tick1 = flg_reg.t1_run & (~mod_reg.t1_gate | act_b)
            & (mod_reg.count_sel1 ? pin_fall[stf_pkg::STF_PIN_EVENT_1]
                                   : base1);                                // see RULE15, RULE18
    end
  end

  // Counter arithmetic
  always_comb begin
    step0 = count_step(mode0, t0_low_reg, t0_high_reg, tick0);
    step1 = count_step(mode1, t1_low_reg, t1_high_reg, tick1);
    if (split) begin
      step0.low  = t0_low_reg + {7'h00, tick0};                             // see RULE1
      step0.ovf  = tick0 & (t0_low_reg == stf_pkg::STF_BYTE_MAX);           // see RULE2
      step0.high = t0_high_reg + {7'h00, tick_high};                        // see RULE1, RULE4
    end
    set_tf0 = step0.ovf;                                                    // see RULE17
    set_tf1 = split ? (tick_high & (t0_high_reg == stf_pkg::STF_BYTE_MAX))
                    : step1.ovf;                                            // see RULE6, RULE7
  end

  // Register file next state
  always_comb begin
    flg_next      = flg_reg;
    mod_next      = mod_reg;
    t0_low_next   = step0.low;
    t0_high_next  = step0.high;
    t1_low_next   = step1.low;
    t1_high_next  = step1.high;
    rdata_next    = rdata_reg;
    t1_pulse_next = step1.ovf;                                              // see RULE8
    act_a_next    = act_a;
    act_b_next    = act_b;
    wr_flg        = sfr_wr_i & (sfr_addr_i == stf_pkg::STF_ADDR_RUN_FLAGS);
    edge_a        = act_a & ~act_a_reg;
    edge_b        = act_b & ~act_b_reg;

    // Software byte writes win over a count in the same cycle
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        stf_pkg::STF_ADDR_MODE:    mod_next     = stf_pkg::stf_mod_t'(sfr_wdata_i);
        stf_pkg::STF_ADDR_T0_LOW:  t0_low_next  = sfr_wdata_i;
        stf_pkg::STF_ADDR_T0_HIGH: t0_high_next = sfr_wdata_i;
        stf_pkg::STF_ADDR_T1_LOW:  t1_low_next  = sfr_wdata_i;
        stf_pkg::STF_ADDR_T1_HIGH: t1_high_next = sfr_wdata_i;
        default:                   mod_next     = mod_reg;
      endcase
    end

    // Control bits only change by write; the count is never cleared by them
    if (wr_flg) begin
      flg_next.t1_run  = sfr_wdata_i[stf_pkg::STF_POS_T1_RUN];             // see RULE18
      flg_next.t0_run  = sfr_wdata_i[stf_pkg::STF_POS_T0_RUN];             // see RULE18
      flg_next.xb_trig = sfr_wdata_i[stf_pkg::STF_POS_XB_TRIG];            // see RULE13
      flg_next.xa_trig = sfr_wdata_i[stf_pkg::STF_POS_XA_TRIG];            // see RULE13
    end

    // Overflow flags: a set in the clearing cycle wins
    flg_next.t0_ovf = set_tf0 | (wr_flg ? sfr_wdata_i[stf_pkg::STF_POS_T0_OVF]
                      : flg_reg.t0_ovf & ~irq_vector_ack_i[stf_pkg::STF_ACK_T0]); // see RULE17
    flg_next.t1_ovf = set_tf1 | (wr_flg ? sfr_wdata_i[stf_pkg::STF_POS_T1_OVF]
                      : flg_reg.t1_ovf & ~irq_vector_ack_i[stf_pkg::STF_ACK_T1]); // see RULE6, RULE17

    // Trigger type of the new value applies from the cycle after the write
    if (flg_reg.xa_trig) begin
      flg_next.xa_flag = edge_a | (wr_flg ? sfr_wdata_i[stf_pkg::STF_POS_XA_FLAG]
                         : flg_reg.xa_flag & ~irq_vector_ack_i[stf_pkg::STF_ACK_XA]); // see RULE10, RULE11
    end else begin
      flg_next.xa_flag = act_a;                                             // see RULE12, RULE13
    end
    if (flg_reg.xb_trig) begin
      flg_next.xb_flag = edge_b | (wr_flg ? sfr_wdata_i[stf_pkg::STF_POS_XB_FLAG]
                         : flg_reg.xb_flag & ~irq_vector_ack_i[stf_pkg::STF_ACK_XB]); // see RULE10, RULE11
    end else begin
      flg_next.xb_flag = act_b;                                             // see RULE12, RULE13
    end

    if (sfr_rd_i) begin
      case (sfr_addr_i)
        stf_pkg::STF_ADDR_RUN_FLAGS: rdata_next = flg_reg;
        stf_pkg::STF_ADDR_MODE:      rdata_next = mod_reg;
        stf_pkg::STF_ADDR_T0_LOW:    rdata_next = t0_low_reg;
        stf_pkg::STF_ADDR_T0_HIGH:   rdata_next = t0_high_reg;
        stf_pkg::STF_ADDR_T1_LOW:    rdata_next = t1_low_reg;
        stf_pkg::STF_ADDR_T1_HIGH:   rdata_next = t1_high_reg;
        default:                     rdata_next = stf_pkg::STF_RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flg_reg      <= stf_pkg::stf_flg_t'(stf_pkg::STF_RST_RUN_FLAGS);
      mod_reg      <= stf_pkg::stf_mod_t'(stf_pkg::STF_RST_MODE);
      t0_low_reg   <= stf_pkg::STF_RST_COUNT;
      t0_high_reg  <= stf_pkg::STF_RST_COUNT;
      t1_low_reg   <= stf_pkg::STF_RST_COUNT;
      t1_high_reg  <= stf_pkg::STF_RST_COUNT;
      rdata_reg    <= stf_pkg::STF_RDATA_UNMAPPED;
      t1_pulse_reg <= 1'b0;
      act_a_reg    <= 1'b0;
      act_b_reg    <= 1'b0;
    end else begin
      flg_reg      <= flg_next;
      mod_reg      <= mod_next;
      t0_low_reg   <= t0_low_next;
      t0_high_reg  <= t0_high_next;
      t1_low_reg   <= t1_low_next;
      t1_high_reg  <= t1_high_next;
      rdata_reg    <= rdata_next;
      t1_pulse_reg <= t1_pulse_next;
      act_a_reg    <= act_a_next;
      act_b_reg    <= act_b_next;
    end
  end

  assign sfr_rdata_o                   = rdata_reg;
  assign ext_irq_a_flag_o              = flg_reg.xa_flag;
  assign first_timer_overflow_flag_o   = flg_reg.t0_ovf;
  assign ext_irq_b_flag_o              = flg_reg.xb_flag;
  assign second_timer_overflow_flag_o  = flg_reg.t1_ovf;
  assign second_timer_overflow_pulse_o = t1_pulse_reg;

endmodule : stf_timer_core

// file: stf_timer_core_assertions.sv
module stf_timer_core_assertions (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Configuration and pins
  input wire logic       prescale_tick_i,
  input wire logic       first_timer_sysclk_select_i,
  input wire logic       second_timer_sysclk_select_i,
  input wire logic       ext_irq_a_polarity_i,
  input wire logic       ext_irq_b_polarity_i,
  input wire logic       ext_irq_a_input_i,
  input wire logic       ext_irq_b_input_i,
  input wire logic       first_timer_event_i,
  input wire logic       second_timer_event_i,
  // Interrupt controller
  input wire logic [3:0] irq_vector_ack_i,
  input wire logic       ext_irq_a_flag_o,
  input wire logic       first_timer_overflow_flag_o,
  input wire logic       ext_irq_b_flag_o,
  input wire logic       second_timer_overflow_flag_o,
  input wire logic       second_timer_overflow_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Shadow of software-only bits: {run1, run0, trig_b, trig_a} and the mode byte
  logic [3:0] ctl_reg, ctl_next;
  logic [7:0] mode_reg, mode_next;
  logic       wr_flags;
  assign wr_flags = sfr_wr_i && (sfr_addr_i == stf_pkg::STF_ADDR_RUN_FLAGS);

  always_comb begin
    ctl_next = ctl_reg;
    mode_next = mode_reg;
    if (wr_flags) begin
      ctl_next = {sfr_wdata_i[6], sfr_wdata_i[4], sfr_wdata_i[2], sfr_wdata_i[0]};
    end
    if (sfr_wr_i && (sfr_addr_i == stf_pkg::STF_ADDR_MODE)) begin
      mode_next = sfr_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= 4'h0;
      mode_reg <= 8'h00;
    end else begin
      ctl_reg <= ctl_next;
      mode_reg <= mode_next;
    end
  end

  property p_rd_ctl;
    sfr_rd_i && sfr_addr_i == 8'h88 |=>
      {sfr_rdata_o[6], sfr_rdata_o[4], sfr_rdata_o[2], sfr_rdata_o[0]} == $past(ctl_reg);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("run or trigger bits read back wrong");
  property p_rd_flags;
    sfr_rd_i && sfr_addr_i == 8'h88 |=> {sfr_rdata_o[7], sfr_rdata_o[5], sfr_rdata_o[3],
      sfr_rdata_o[1]} == $past({second_timer_overflow_flag_o, first_timer_overflow_flag_o,
      ext_irq_b_flag_o, ext_irq_a_flag_o});
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag bits read back wrong");
  property p_rd_mode;
    sfr_rd_i && sfr_addr_i == 8'h89 |=> sfr_rdata_o == $past(mode_reg);
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode byte read back wrong");
  property p_rd_unmapped;
    sfr_rd_i && (sfr_addr_i < 8'h88 || sfr_addr_i > 8'h8d) |=> sfr_rdata_o == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_sw_set;
    wr_flags && sfr_wdata_i[5] && !irq_vector_ack_i[1] |=> first_timer_overflow_flag_o;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("overflow flag not written");
  property p_lvl_a;
    (!ctl_reg[0] && ext_irq_a_input_i == ext_irq_a_polarity_i)[*7] |-> ext_irq_a_flag_o;
  endproperty
  a_lvl_a: assert property (p_lvl_a) else $error("level flag a not following input");
  property p_lvl_b;
    (!ctl_reg[1] && ext_irq_b_input_i != ext_irq_b_polarity_i)[*7] |-> !ext_irq_b_flag_o;
  endproperty
  a_lvl_b: assert property (p_lvl_b) else $error("level flag b set while idle");
  property p_edge_hold;
    ctl_reg[0] && ext_irq_a_flag_o && !wr_flags && !irq_vector_ack_i[0] |=> ext_irq_a_flag_o;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag a lost");
  property p_split_tf1;
    (mode_reg[1:0] == 2'h3 && !ctl_reg[3] && !wr_flags)[*3] |=>
      !$rose(second_timer_overflow_flag_o);
  endproperty
  a_split_tf1: assert property (p_split_tf1) else $error("second flag set while split");
endmodule : stf_timer_core_assertions

bind stf_timer_core stf_timer_core_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .prescale_tick_i(prescale_tick_i),
  .first_timer_sysclk_select_i(first_timer_sysclk_select_i),
  .second_timer_sysclk_select_i(second_timer_sysclk_select_i),
  .ext_irq_a_polarity_i(ext_irq_a_polarity_i), .ext_irq_b_polarity_i(ext_irq_b_polarity_i),
  .ext_irq_a_input_i(ext_irq_a_input_i), .ext_irq_b_input_i(ext_irq_b_input_i),
  .first_timer_event_i(first_timer_event_i), .second_timer_event_i(second_timer_event_i),
  .irq_vector_ack_i(irq_vector_ack_i), .ext_irq_a_flag_o(ext_irq_a_flag_o),
  .first_timer_overflow_flag_o(first_timer_overflow_flag_o),
  .ext_irq_b_flag_o(ext_irq_b_flag_o),
  .second_timer_overflow_flag_o(second_timer_overflow_flag_o),
  .second_timer_overflow_pulse_o(second_timer_overflow_pulse_o));

// file: stf_timer_core_test.sv
module stf_timer_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0;
  logic       sel0 = 1'b0, sel1 = 1'b0, pol_a = 1'b0, pol_b = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, w;
  logic [3:0] ack = 4'h0;
  logic [3:0] flg;
  logic       pa, pb, ev0, ev1, pulse;
  int         num_errors = 0, checks = 0, cycles = 0, npulse = 0;

  stf_timer_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .prescale_tick_i(tick),
    .first_timer_sysclk_select_i(sel0), .second_timer_sysclk_select_i(sel1),
    .ext_irq_a_polarity_i(pol_a), .ext_irq_b_polarity_i(pol_b), .ext_irq_a_input_i(pa),
    .ext_irq_b_input_i(pb), .first_timer_event_i(ev0), .second_timer_event_i(ev1),
    .irq_vector_ack_i(ack), .ext_irq_a_flag_o(flg[0]), .first_timer_overflow_flag_o(flg[2]),
    .ext_irq_b_flag_o(flg[1]), .second_timer_overflow_flag_o(flg[3]),
    .second_timer_overflow_pulse_o(pulse));
  stf_pin_model pin_u (.clk_i(clk_i), .ext_irq_a_input_o(pa), .ext_irq_b_input_o(pb),
    .first_timer_event_o(ev0), .second_timer_event_o(ev1));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (pulse === 1'b1) npulse++;
    if (cycles == 6000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : sw
  task automatic sr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a; rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
    d = rdata;
  endtask : sr

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      sr(8'h88 + 8'(i), v); chk(v, 8'h00);
    end
    sr(8'h90, v); chk(v, 8'h00);
    $display("reset values done");
  endtask : t_reset
  task automatic t_split;
    sel0 <= 1'b1;
    sw(8'h89, 8'h03); sw(8'h8a, 8'hfe); sw(8'h8c, 8'hf0); sw(8'h88, 8'h10);
    wt(10);
    sr(8'h88, v); chk(v, 8'h30);
    sr(8'h8c, v); chk(v, 8'hf0);
    sw(8'h88, 8'h40);
    wt(25);
    sr(8'h88, v); chk(v, 8'hc0);
    sr(8'h8a, v); wt(5); sr(8'h8a, w); chk(w, v);
    sw(8'h88, 8'h00);
    $display("split counters done");
  endtask : t_split
  task automatic t_timer1;
    sel1 <= 1'b1;
    sw(8'h89, 8'h23); sw(8'h8b, 8'hfe); sw(8'h8d, 8'hfe);
    npulse = 0; wt(20);
    chk(8'(npulse != 0), 8'h01);
    sr(8'h88, v); chk(v, 8'h00);
    sw(8'h89, 8'h33); wt(5);
    npulse = 0; wt(20);
    chk(8'(npulse), 8'h00);
    $display("second timer while split done");
  endtask : t_timer1
  task automatic t_ack;
    logic [7:0] exp;
    int         pos [4] = '{1, 5, 3, 7};
    sw(8'h88, 8'h05); sw(8'h88, 8'haf);
    exp = 8'haf;
    sr(8'h88, v); chk(v, exp);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i); ack <= 4'h1 << i;
      @(posedge clk_i); ack <= 4'h0;
      exp[pos[i]] = 1'b0;
      sr(8'h88, v); chk(v, exp);
      chk({4'h0, flg}, {4'h0, exp[7], exp[5], exp[3], exp[1]});
    end
    sw(8'h88, 8'h00);
    $display("vector clear done");
  endtask : t_ack
  task automatic t_ext;
    int ieb, itb;
    for (int i = 0; i < 2; i++) begin
      ieb = i ? 3 : 1; itb = i ? 2 : 0;
      @(posedge clk_i); if (i == 0) pol_a <= 1'b1; else pol_b <= 1'b1;
      pin_u.set_ext(i, 1'b1); wt(8);
      sr(8'h88, v); chk(v, 8'h01 << ieb);
      pin_u.set_ext(i, 1'b0); wt(8);
      sr(8'h88, v); chk(v, 8'h00);
      sw(8'h88, 8'h01 << itb);
      pin_u.set_ext(i, 1'b1); wt(8); pin_u.set_ext(i, 1'b0); wt(8);
      sr(8'h88, v); chk(v, (8'h01 << itb) | (8'h01 << ieb));
      sw(8'h88, 8'h01 << itb);
      sr(8'h88, v); chk(v, 8'h01 << itb);
      sw(8'h88, 8'h00);
      @(posedge clk_i); if (i == 0) pol_a <= 1'b0; else pol_b <= 1'b0;
      pin_u.set_ext(i, 1'b1); wt(8);
    end
    $display("external flags done");
  endtask : t_ext
  task automatic t_gate;
    sw(8'h89, 8'h0b); sw(8'h8a, 8'h00); sw(8'h88, 8'h10);
    wt(10);
    sr(8'h8a, v); chk(v, 8'h00);
    pin_u.set_ext(0, 1'b0); wt(10);
    sr(8'h8a, v); chk(8'(v != 8'h00), 8'h01);
    pin_u.set_ext(0, 1'b1); sw(8'h88, 8'h00);
    $display("gating done");
  endtask : t_gate
  task automatic t_events;
    sel0 <= 1'b0;
    sw(8'h89, 8'h07); sw(8'h8a, 8'h00); sw(8'h8c, 8'h00); sw(8'h88, 8'h50);
    pin_u.event_falls(3); wt(6);
    sr(8'h8a, v); chk(v, 8'h03);
    sr(8'h8c, v); chk(v, 8'h00);
    repeat (5) begin
      @(posedge clk_i); tick <= 1'b1;
      @(posedge clk_i); tick <= 1'b0;
    end
    sr(8'h8c, v); chk(v, 8'h05);
    sw(8'h88, 8'h00);
    $display("event counting done");
  endtask : t_events

  initial begin
    wt(4);
    rst_i <= 1'b0;
    t_reset(); t_split(); t_timer1(); t_ack(); t_ext(); t_gate(); t_events();
    final_report();
  end
endmodule : stf_timer_core_test
